// file: core/tioac_pkg.sv
`default_nettype none
package tioac_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the Wishbone slave.
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_IOCTRL = 5'h00;
    localparam logic [4:0] OFS_MODE = 5'h04;
    localparam logic [4:0] OFS_GRA0 = 5'h08;
    localparam logic [4:0] OFS_GRC0 = 5'h0c;
    localparam logic [4:0] OFS_GRA1 = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_MASK = 5'h18;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int IO_A0_LSB = 0;
    localparam int IO_C0_LSB = 4;
    localparam int IO_A1_LSB = 8;
    localparam int MODE_BUF_A_BIT = 0;
    localparam int MODE_PSC_LSB = 4;
    localparam int EV_A0_BIT = 0;
    localparam int EV_C0_BIT = 1;
    localparam int EV_A1_BIT = 2;
    localparam int NUM_EV = 3;

    // ------------------------------------------------------------------
    // Values after reset and code fields.
    // ------------------------------------------------------------------
    localparam logic [3:0] IO_RESET = 4'h0;
    localparam logic [2:0] PSC_RESET = 3'h0;
    localparam logic [2:0] PSC_UNDIVIDED = 3'h0;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;

    // One timer pin as driven by the block.
    typedef struct packed {
        logic level;
        logic oe;
    } tioac_pin_s;

endpackage : tioac_pkg
`default_nettype wire

// file: core/tioac_top.sv
// Summary of operation
// - Four-bit field selects register A function
// - Channel 0 second field selects register C
// - Bit 2 sets initial level; 0x00 disables
// - Codes 0x10 drive pin high on match
// - Codes 0x11 toggle pin on match
// - Code 1000 captures on pin rising edge
// - Code 1001 captures on pin falling edge
// - Codes 101x capture on both pin edges
// - Channel 0 11xx captures on channel 1 count
// - Channel 1 A 11xx captures on A0 event
// - Buffer mode suppresses all register C events
// - Undivided channel 1 clock gives no capture
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// One general register with its I/O control decode.
// ----------------------------------------------------------------------
module tioac_unit #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic [3:0] code,
    input wire logic code_wr,
    input wire logic [3:0] code_new,
    input wire logic inhibit,
    // Counter, pin and neighbour event
    input wire logic [CW-1:0] counter,
    input wire logic pin_in,
    input wire logic ext_event,
    // Software access to the register
    input wire logic reg_wr,
    input wire logic [CW-1:0] reg_wdata,
    // Results
    output logic [CW-1:0] reg_value,
    output tioac_pkg::tioac_pin_s pin,
    output logic event_pulse
);

    logic [CW-1:0] reg_q;
    logic level_q;
    logic pin_prev_q;
    logic eq_prev_q;
    logic eq;
    logic match;
    logic cap_mode;
    logic capture;

    // Compare mode when bit 3 is clear, capture mode otherwise.
    assign cap_mode = code[3];
    assign eq = (counter == reg_q);
    // A match is taken only on the first cycle of equality, so a
    // counter that dwells on one value does not toggle repeatedly.
    assign match = !cap_mode && eq && !eq_prev_q && !inhibit;

    // Capture source selection.
    always_comb begin
        capture = 1'b0;
        if (cap_mode && !inhibit) begin
            if (code[2]) begin
                capture = ext_event;
            end else begin
                case (code[1:0])
                    tioac_pkg::CAP_RISE:
                        capture = pin_in && !pin_prev_q;
                    tioac_pkg::CAP_FALL:
                        capture = !pin_in && pin_prev_q;
                    default: capture = pin_in != pin_prev_q;
                endcase
            end
        end
    end

    // Pin history and equality history for edge detection.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_prev_q <= 1'b0;
            eq_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_in;
            eq_prev_q <= eq;
        end
    end

    // General register: a capture beats a software write.
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_q <= '0;
        end else if (capture) begin
            reg_q <= counter;
        end else if (reg_wr) begin
            reg_q <= reg_wdata;
        end
    end

    // Output level: initial level on code write, then match actions.
    always_ff @(posedge clk) begin
        if (rst) begin
            level_q <= 1'b0;
        end else if (code_wr && !code_new[3]) begin
            level_q <= code_new[2];
        end else if (match) begin
            case (code[1:0])
                tioac_pkg::ACT_LOW: level_q <= 1'b0;
                tioac_pkg::ACT_HIGH: level_q <= 1'b1;
                tioac_pkg::ACT_TOGGLE: level_q <= !level_q;
                default: level_q <= level_q;
            endcase
        end
    end

    // Pin driven only in compare mode with a non-disabled code.
    assign pin.level = level_q;
    assign pin.oe = !cap_mode && (code[1:0] != tioac_pkg::ACT_NONE);
    assign reg_value = reg_q;
    assign event_pulse = match || capture;

endmodule : tioac_unit

// ----------------------------------------------------------------------
// Top: Wishbone registers, three general registers, interrupt.
// ----------------------------------------------------------------------
module tioac_top #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Counters of channels 0 and 1
    input wire logic [CW-1:0] chan0_counter,
    input wire logic [CW-1:0] chan1_counter,
    input wire logic chan1_count_tick,
    // Timer pins
    input wire logic chan0_pin_a_in,
    output logic chan0_pin_a_out,
    output logic chan0_pin_a_oe,
    input wire logic chan0_pin_c_in,
    output logic chan0_pin_c_out,
    output logic chan0_pin_c_oe,
    input wire logic chan1_pin_a_in,
    output logic chan1_pin_a_out,
    output logic chan1_pin_a_oe,
    // Interrupt
    output logic irq
);

    logic [3:0] io_a0_q;
    logic [3:0] io_c0_q;
    logic [3:0] io_a1_q;
    logic buffer_mode_a_q;
    logic [2:0] psc1_q;
    logic [tioac_pkg::NUM_EV-1:0] status_q;
    logic [tioac_pkg::NUM_EV-1:0] mask_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic req;
    logic wr;
    logic rd;
    logic io_wr;
    logic [3:0] io_a0_new;
    logic [3:0] io_c0_new;
    logic [3:0] io_a1_new;
    logic tick_valid;
    logic ev_a0;
    logic ev_c0;
    logic ev_a1;
    logic [tioac_pkg::NUM_EV-1:0] events;
    logic [CW-1:0] gra0;
    logic [CW-1:0] grc0;
    logic [CW-1:0] gra1;
    tioac_pkg::tioac_pin_s pin_a0;
    tioac_pkg::tioac_pin_s pin_c0;
    tioac_pkg::tioac_pin_s pin_a1;

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------

    // A request is served on its first cycle; ack follows one cycle
    // later, so back-to-back strobes are never taken twice.
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign io_wr = wr && (wb_adr_i == tioac_pkg::OFS_IOCTRL);
    assign io_a0_new = wb_dat_i[tioac_pkg::IO_A0_LSB +: 4];
    assign io_c0_new = wb_dat_i[tioac_pkg::IO_C0_LSB +: 4];
    assign io_a1_new = wb_dat_i[tioac_pkg::IO_A1_LSB +: 4];

    // Acknowledge one cycle after the request.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // I/O control fields; channel 1 A lives in byte lane 1.
    always_ff @(posedge clk) begin
        if (rst) begin
            io_a0_q <= tioac_pkg::IO_RESET;
            io_c0_q <= tioac_pkg::IO_RESET;
            io_a1_q <= tioac_pkg::IO_RESET;
        end else if (io_wr) begin
            io_a0_q <= io_a0_new;
            io_c0_q <= io_c0_new;
            if (wb_sel_i[1]) begin
                io_a1_q <= io_a1_new;
            end
        end
    end

    // Mode bits: buffer mode for A and the channel 1 prescaler select.
    always_ff @(posedge clk) begin
        if (rst) begin
            buffer_mode_a_q <= 1'b0;
            psc1_q <= tioac_pkg::PSC_RESET;
        end else if (wr && (wb_adr_i == tioac_pkg::OFS_MODE)) begin
            buffer_mode_a_q <= wb_dat_i[tioac_pkg::MODE_BUF_A_BIT];
            psc1_q <= wb_dat_i[tioac_pkg::MODE_PSC_LSB +: 3];
        end
    end

    // Interrupt mask.
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= '0;
        end else if (wr && (wb_adr_i == tioac_pkg::OFS_MASK)) begin
            mask_q <= wb_dat_i[tioac_pkg::NUM_EV-1:0];
        end
    end

    // Sticky status; a read clears it but a same-cycle event survives.
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= '0;
        end else if (rd && (wb_adr_i == tioac_pkg::OFS_STATUS)) begin
            status_q <= events;
        end else begin
            status_q <= status_q | events;
        end
    end

    // Read data is registered with the ack; unmapped offsets read zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (rd) begin
            case (wb_adr_i)
                tioac_pkg::OFS_IOCTRL:
                    rdata_q <= {20'h0_0000, io_a1_q, io_c0_q, io_a0_q};
                tioac_pkg::OFS_MODE:
                    rdata_q <= {25'h000_0000, psc1_q, 3'h0,
                                buffer_mode_a_q};
                tioac_pkg::OFS_GRA0: rdata_q <= 32'(gra0);
                tioac_pkg::OFS_GRC0: rdata_q <= 32'(grc0);
                tioac_pkg::OFS_GRA1: rdata_q <= 32'(gra1);
                tioac_pkg::OFS_STATUS: rdata_q <= 32'(status_q);
                tioac_pkg::OFS_MASK: rdata_q <= 32'(mask_q);
                default: rdata_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Capture sources and channel units.
    // ------------------------------------------------------------------

    // Counting on the undivided clock gives no usable capture trigger.
    assign tick_valid = chan1_count_tick &&
                        (psc1_q != tioac_pkg::PSC_UNDIVIDED);

    // Channel 0, register A.
    tioac_unit #(.CW(CW)) u_a0 (
        .clk(clk),
        .rst(rst),
        .code(io_a0_q),
        .code_wr(io_wr),
        .code_new(io_a0_new),
        .inhibit(1'b0),
        .counter(chan0_counter),
        .pin_in(chan0_pin_a_in),
        .ext_event(tick_valid),
        .reg_wr(wr && (wb_adr_i == tioac_pkg::OFS_GRA0)),
        .reg_wdata(wb_dat_i[CW-1:0]),
        .reg_value(gra0),
        .pin(pin_a0),
        .event_pulse(ev_a0)
    );

    // Channel 0, register C; silent while it acts as A's buffer.
    tioac_unit #(.CW(CW)) u_c0 (
        .clk(clk),
        .rst(rst),
        .code(io_c0_q),
        .code_wr(io_wr),
        .code_new(io_c0_new),
        .inhibit(buffer_mode_a_q),
        .counter(chan0_counter),
        .pin_in(chan0_pin_c_in),
        .ext_event(tick_valid),
        .reg_wr(wr && (wb_adr_i == tioac_pkg::OFS_GRC0)),
        .reg_wdata(wb_dat_i[CW-1:0]),
        .reg_value(grc0),
        .pin(pin_c0),
        .event_pulse(ev_c0)
    );

    // Channel 1, register A; its neighbour source is channel 0 A.
    tioac_unit #(.CW(CW)) u_a1 (
        .clk(clk),
        .rst(rst),
        .code(io_a1_q),
        .code_wr(io_wr && wb_sel_i[1]),
        .code_new(io_a1_new),
        .inhibit(1'b0),
        .counter(chan1_counter),
        .pin_in(chan1_pin_a_in),
        .ext_event(ev_a0),
        .reg_wr(wr && (wb_adr_i == tioac_pkg::OFS_GRA1)),
        .reg_wdata(wb_dat_i[CW-1:0]),
        .reg_value(gra1),
        .pin(pin_a1),
        .event_pulse(ev_a1)
    );

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------

    // Event vector in status bit order.
    always_comb begin
        events = '0;
        events[tioac_pkg::EV_A0_BIT] = ev_a0;
        events[tioac_pkg::EV_C0_BIT] = ev_c0;
        events[tioac_pkg::EV_A1_BIT] = ev_a1;
    end

    // Pins, bus answer and interrupt level.
    assign chan0_pin_a_out = pin_a0.level;
    assign chan0_pin_a_oe = pin_a0.oe;
    assign chan0_pin_c_out = pin_c0.level;
    assign chan0_pin_c_oe = pin_c0.oe;
    assign chan1_pin_a_out = pin_a1.level;
    assign chan1_pin_a_oe = pin_a1.oe;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign irq = |(status_q & mask_q);

endmodule : tioac_top

`default_nettype wire

// file: test/tioac_far.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Far side: channel counters, count tick and the three pin wires.
// ----------------------------------------------------------------------
module tioac_far (
    // Control from the bench
    input wire logic clk,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load0,
    input wire logic tick_req,
    input wire logic [2:0] ext_lvl,
    // Pin drive from the block
    input wire logic [2:0] dut_out,
    input wire logic [2:0] dut_oe,
    // Toward the block
    output logic [15:0] cnt0,
    output logic [15:0] cnt1,
    output logic tick,
    output logic [2:0] pin_in
);
    // Channel 0 counts each cycle while running; a load freezes a value.
    always_ff @(posedge clk) begin
        if (load) begin
            cnt0 <= load0;
        end else if (run) begin
            cnt0 <= cnt0 + 16'h0001;
        end
    end
    // Channel 1 steps once per tick, so a capture sees a known value.
    always_ff @(posedge clk) begin
        if (load) begin
            cnt1 <= ~load0;
            tick <= 1'b0;
        end else begin
            tick <= tick_req && !tick;
            cnt1 <= cnt1 + {15'h0000, tick};
        end
    end
    // A pin the block drives shows its level; otherwise the bench's.
    assign pin_in = (dut_oe & dut_out) | (~dut_oe & ext_lvl);
endmodule : tioac_far
`default_nettype wire

// file: test/tioac_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the I/O control block.
// ----------------------------------------------------------------------
module tioac_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and interrupt
    input wire logic chan0_pin_a_out,
    input wire logic chan0_pin_a_oe,
    input wire logic chan0_pin_c_out,
    input wire logic chan0_pin_c_oe,
    input wire logic chan1_pin_a_oe,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic req;
    logic ioc_wr;
    logic clr;
    logic [31:0] wdat_q;
    // A code drives the pin only for compare codes other than 0x00.
    function automatic logic drv(input logic [3:0] c);
        return !c[3] && c[1:0] != 2'b00;
    endfunction : drv
    // Decodes of a taken request; write data kept for the next edge.
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ioc_wr = req && wb_we_i && wb_sel_i[0]
        && wb_adr_i == tioac_pkg::OFS_IOCTRL;
    assign clr = req && (wb_adr_i == tioac_pkg::OFS_STATUS
        || wb_adr_i == tioac_pkg::OFS_MASK);
    always_ff @(posedge clk) begin
        wdat_q <= wb_dat_i;
    end
    ack_after_req_a: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    reset_quiet_a: assert property (
        $fell(rst) |-> !chan0_pin_a_oe && !chan0_pin_c_oe
        && !chan1_pin_a_oe && !irq)
        else $error("pins or irq active after reset");
    a0_mode_a: assert property (
        ioc_wr |=> chan0_pin_a_oe == drv(wdat_q[3:0])
        && (wdat_q[3] || chan0_pin_a_out == wdat_q[2]))
        else $error("ch0 A pin wrong after code write");
    c0_mode_a: assert property (
        ioc_wr |=> chan0_pin_c_oe == drv(wdat_q[7:4])
        && (wdat_q[7] || chan0_pin_c_out == wdat_q[6]))
        else $error("ch0 C pin wrong after code write");
    a1_mode_a: assert property (
        ioc_wr && wb_sel_i[1] |=> chan1_pin_a_oe == drv(wdat_q[11:8]))
        else $error("ch1 A enable wrong after code write");
    unmapped_zero_a: assert property (
        req && !wb_we_i && wb_adr_i == 5'h1c |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    irq_drop_a: assert property (
        $fell(irq) |-> $past(clr) || $past(clr, 2))
        else $error("irq fell without status or mask access");
    cover property (irq);
    cover property (ioc_wr && wb_dat_i[3:0] == 4'h3);
    cover property ($fell(irq));
endmodule : tioac_chk

bind tioac_top tioac_chk i_chk (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .chan0_pin_a_out(chan0_pin_a_out), .chan0_pin_a_oe(chan0_pin_a_oe),
    .chan0_pin_c_out(chan0_pin_c_out), .chan0_pin_c_oe(chan0_pin_c_oe),
    .chan1_pin_a_oe(chan1_pin_a_oe), .irq(irq));
`default_nettype wire

// file: test/tioac_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tioac_tb;
    // ------------------------------------------------------------------
    // Bench signals, model registers and counters.
    // ------------------------------------------------------------------
    logic clk, rst, cyc, stb, we, ack, irq, run, load, tick_req, tick;
    logic [4:0] adr;
    logic [3:0] sel, c4;
    logic [31:0] wdat, rdat, q;
    logic [15:0] load0, cnt0, cnt1, v, m_a0, m_a1, m_c0;
    logic [2:0] ext_lvl, pin_in, pout, poe;
    int err_total = 0, tests_run = 0, clk_count = 0;
    tioac_top #(.CW(16)) i_dut (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .chan0_counter(cnt0),
        .chan1_counter(cnt1), .chan1_count_tick(tick),
        .chan0_pin_a_in(pin_in[0]), .chan0_pin_a_out(pout[0]),
        .chan0_pin_a_oe(poe[0]), .chan0_pin_c_in(pin_in[1]),
        .chan0_pin_c_out(pout[1]), .chan0_pin_c_oe(poe[1]),
        .chan1_pin_a_in(pin_in[2]), .chan1_pin_a_out(pout[2]),
        .chan1_pin_a_oe(poe[2]), .irq(irq));
    tioac_far i_far (
        .clk(clk), .run(run), .load(load), .load0(load0),
        .tick_req(tick_req), .ext_lvl(ext_lvl), .dut_out(pout),
        .dut_oe(poe), .cnt0(cnt0), .cnt1(cnt1), .tick(tick),
        .pin_in(pin_in));
    // Clock, and a watchdog so a missing ack cannot hang the run.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        clk_count <= clk_count + 1;
        if (clk_count == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    // One classic cycle; the request stands until ack is sampled.
    task automatic wb(input logic w, input logic [4:0] a,
            input logic [31:0] d);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : wb
    task automatic chk(input string n, input logic [31:0] e, s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), {16'h0000, e}, q);
    endtask : rd
    // Freeze the counters at a random value before a capture.
    task automatic ldc;
        v = 16'($urandom);
        {load0, load} <= {v, 1'b1};
        @(posedge clk);
        load <= 1'b0;
    endtask : ldc
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // Main sequence; every input moves just after a rising edge.
    initial begin
        {cyc, stb, we, adr, sel, wdat, run, tick_req, ext_lvl} = '0;
        {load0, load, rst} = {16'h8000, 2'b11};
        void'($urandom(32'h51e6));
        repeat (10) @(posedge clk);
        {rst, load} <= 2'b00;
        rd(tioac_pkg::OFS_IOCTRL, 16'h0000);
        chk("enables", 32'h0, 32'(poe));
        rd(5'h1c, 16'h0000);
        for (int c = 0; c < 16; c++) begin
            wb(1'b1, tioac_pkg::OFS_IOCTRL, {20'h0, {3{4'(c)}}});
            chk("enables", 32'({3{c < 8 && c[1:0] != 2'b00}}),
                32'(poe));
            if (c < 8) begin
                chk("levels", 32'({3{c[2]}}), 32'(pout));
            end
        end
        rd(tioac_pkg::OFS_IOCTRL, 16'h0fff);
        wb(1'b1, tioac_pkg::OFS_GRA0, 32'h0000_0010);
        wb(1'b1, tioac_pkg::OFS_GRC0, 32'h0000_0000);
        wb(1'b1, tioac_pkg::OFS_GRA1, 32'h0000_0000);
        wb(1'b1, tioac_pkg::OFS_MASK, 32'h0000_0001);
        wb(1'b0, tioac_pkg::OFS_STATUS, 32'h0000_0000);
        // Each compare code other than 0x00: one pass of the counter over 16'h0010.
        // Channel 1 A (11xx) copies its own counter at every match.
        for (int k = 0; k < 6; k++) begin
            c4 = (k < 3) ? 4'(k + 1) : 4'(k + 2);
            {load0, load} <= {16'h0000, 1'b1};
            @(posedge clk);
            load <= 1'b0;
            wb(1'b1, tioac_pkg::OFS_IOCTRL, {20'h0, 8'hc0, c4});
            run <= 1'b1;
            repeat (30) @(posedge clk);
            run <= 1'b0;
            chk("match level", 32'((c4[1:0] == 2'b11) ? !c4[2] : c4[1]),
                32'(pout[0]));
        end
        chk("irq set", 32'h1, 32'(irq));
        wb(1'b0, tioac_pkg::OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h1, q & 32'h0000_0001);
        chk("irq clear", 32'h0, 32'(irq));
        {m_a0, m_a1, m_c0} = {16'h0010, 16'hffff, 16'h0000};
        rd(tioac_pkg::OFS_GRA1, m_a1);
        for (int c = 8; c < 12; c++) begin
            wb(1'b1, tioac_pkg::OFS_IOCTRL, {20'h0, 8'hc0, 4'(c)});
            for (int e = 0; e < 2; e++) begin
                ldc();
                ext_lvl[0] <= (e == 0);
                repeat (4) @(posedge clk);
                if ((c == 8 && e == 0) || (c == 9 && e == 1) || c > 9) begin
                    {m_a0, m_a1} = {v, ~v};
                end
                rd(tioac_pkg::OFS_GRA0, m_a0);
                rd(tioac_pkg::OFS_GRA1, m_a1);
            end
        end
        // Channel 1 count as source: undivided clock, then divided.
        for (int p = 0; p < 2; p++) begin
            wb(1'b1, tioac_pkg::OFS_MODE, 32'(p << 4));
            wb(1'b1, tioac_pkg::OFS_IOCTRL, 32'h0000_000c);
            ldc();
            tick_req <= 1'b1;
            @(posedge clk);
            tick_req <= 1'b0;
            repeat (4) @(posedge clk);
            m_a0 = (p == 1) ? v : m_a0;
            rd(tioac_pkg::OFS_GRA0, m_a0);
        end
        // Register C capture with buffer mode on, then off.
        for (int b = 0; b < 2; b++) begin
            wb(1'b1, tioac_pkg::OFS_MODE, 32'(1 - b));
            wb(1'b1, tioac_pkg::OFS_IOCTRL, 32'h0000_0080);
            ldc();
            ext_lvl[1] <= 1'b1;
            repeat (4) @(posedge clk);
            ext_lvl[1] <= 1'b0;
            m_c0 = (b == 1) ? v : m_c0;
            rd(tioac_pkg::OFS_GRC0, m_c0);
        end
        wrap_up();
    end
endmodule : tioac_tb
`default_nettype wire
